/* File: inc/fpec_consts.svh */
// constants for the flash program/erase controller
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH
`define FPEC_KEY_FIRST      8'h73
`define FPEC_KEY_SECOND     8'h8C
`define FPEC_CMD_PAGE_ERASE 8'h95
`define FPEC_CMD_MASS_ERASE 8'h63
`define FPEC_CMD_PROGRAM    8'hA5
`define FPEC_INFO_BASE      16'hFE00
`define FPEC_INFO_LAST      16'hFFFF
`define FPEC_INFO_WORDS     64
`define FPEC_STAT_LOCKED    3'h0
`define FPEC_STAT_KEY1      3'h1
`define FPEC_STAT_UNLOCKED  3'h3
`define FPEC_STAT_PAGE_ARM  3'h4
`define FPEC_STAT_MASS_ARM  3'h5
`define FPEC_STAT_PROG_ARM  3'h6
`define FPEC_STAT_BUSY_BIT  7
`define FPEC_T_PROG_NS      40000
`define FPEC_T_PAGE_NS      10000000
`define FPEC_T_MASS_NS      200000000
`define FPEC_CLK_NS         10
`endif

/* File: inc/fpec_pkg.sv */
// types for the flash program/erase controller
package fpec_pkg;
  typedef enum logic [2:0] {
    FPEC_LOCKED   = 3'b000,
    FPEC_KEY1     = 3'b001,
    FPEC_UNLOCKED = 3'b011,
    FPEC_PAGE_ARM = 3'b100,
    FPEC_MASS_ARM = 3'b101,
    FPEC_PROG_ARM = 3'b110,
    FPEC_BUSY     = 3'b111
  } fpec_state_e;
  typedef enum logic [1:0] {
    FPEC_OP_PROG = 2'b00,
    FPEC_OP_PAGE = 2'b01,
    FPEC_OP_MASS = 2'b10
  } fpec_op_e;
endpackage

/* File: hdl/fpec_ctrl.sv */
// flash program/erase sequencer with unlock guard, protection and info area
`timescale 1ns/100ps
`include "fpec_consts.svh"
// Overview of operation
// - info area sits at FE00H-FFFFH; only the implemented low words answer.
// - info area returns stored trim and calibration words on read.
// - sequencer drives array erase/program strobes and busy timing itself.
// - protection applies per page, per sector and for whole memory.
// - unlock needs 73H then 8CH on consecutive command writes.
// - unlocked controller accepts enable command arming page or mass erase.
// - page erase touches only the page latched from page select at unlock.
// - mass erase arms only when the debugger issues it.
// - any wrong value or out-of-order key relocks at once.
// - command write and status read share one register address.
// - one page open at a time; another page needs a fresh unlock.
module fpec_ctrl #(
  parameter int PAGE_BITS   = 3,
  parameter int SECTOR_BITS = 3,
  parameter int ADDR_BITS   = 16,
  parameter int PROG_CYC    = (`FPEC_T_PROG_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS,
  parameter int PAGE_CYC    = (`FPEC_T_PAGE_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS,
  parameter int MASS_CYC    = (`FPEC_T_MASS_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 NRST,
  input  wire logic                 CMD_WR,
  input  wire logic [7:0]           CMD_WDATA,
  input  wire logic                 CMD_FROM_DEBUG,
  input  wire logic [PAGE_BITS-1:0] PAGE_SEL,
  input  wire logic [7:0]           SECTOR_PROT,
  input  wire logic                 MEM_PROT,
  input  wire logic [PAGE_BITS-1:0] PAGE_PROT_SEL,
  input  wire logic                 PAGE_PROT_EN,
  input  wire logic                 PROG_REQ,
  input  wire logic [ADDR_BITS-1:0] PROG_ADDR,
  input  wire logic [7:0]           PROG_DATA,
  input  wire logic                 INFO_RD,
  input  wire logic [ADDR_BITS-1:0] INFO_ADDR,
  input  wire logic                 INFO_LOAD,
  input  wire logic [7:0]           INFO_LOAD_DATA,
  output logic [7:0]                STATUS_RDATA,
  output logic [7:0]                INFO_RDATA,
  output logic                      INFO_HIT,
  output logic                      ARRAY_PROG,
  output logic                      ARRAY_PAGE_ERASE,
  output logic                      ARRAY_MASS_ERASE,
  output logic [PAGE_BITS-1:0]      ARRAY_PAGE,
  output logic [ADDR_BITS-1:0]      ARRAY_ADDR,
  output logic [7:0]                ARRAY_WDATA,
  output logic                      OP_REFUSED
);
  localparam int CNT_W = $clog2(MASS_CYC + 1);

  fpec_pkg::fpec_state_e state_reg, state_next;
  fpec_pkg::fpec_op_e    op_reg;
  logic [CNT_W-1:0]      cnt_reg;
  logic [PAGE_BITS-1:0]  page_reg;
  logic                  page_open_reg;
  logic [7:0]            info_mem [`FPEC_INFO_WORDS];

  // protection of a target page at three levels
  wire [SECTOR_BITS-1:0] tgt_sector = page_reg[PAGE_BITS-1 -: SECTOR_BITS];
  wire [SECTOR_BITS-1:0] prg_sector = PROG_ADDR[ADDR_BITS-1 -: SECTOR_BITS];
  wire [PAGE_BITS-1:0]   prg_page   = PROG_ADDR[ADDR_BITS-1 -: PAGE_BITS];
  wire page_blocked = MEM_PROT || SECTOR_PROT[tgt_sector] ||
                      (PAGE_PROT_EN && PAGE_PROT_SEL == page_reg);
  wire prog_blocked = MEM_PROT || SECTOR_PROT[prg_sector] ||
                      (PAGE_PROT_EN && PAGE_PROT_SEL == prg_page);
  wire mass_blocked = MEM_PROT || (|SECTOR_PROT);
  wire is_busy   = (state_reg == fpec_pkg::FPEC_BUSY);
  wire cmd_take  = CMD_WR && !is_busy;
  wire prog_page_ok = !page_open_reg ||
                      (PROG_ADDR[ADDR_BITS-1 -: PAGE_BITS] == page_reg);
  wire prog_go   = (state_reg == fpec_pkg::FPEC_PROG_ARM) && PROG_REQ &&
                   !prog_blocked && prog_page_ok;
  wire mass_req  = CMD_WDATA == `FPEC_CMD_MASS_ERASE;
  wire refuse    = cmd_take && (state_reg == fpec_pkg::FPEC_UNLOCKED) &&
                   ((mass_req && (!CMD_FROM_DEBUG || mass_blocked)) ||
                    (CMD_WDATA == `FPEC_CMD_PAGE_ERASE && page_blocked));
  wire cnt_done  = (cnt_reg == '0);

  always_comb begin
    state_next = state_reg;
    if (is_busy) begin
      if (cnt_done) state_next = fpec_pkg::FPEC_LOCKED;
    end else if (cmd_take) begin
      state_next = fpec_pkg::FPEC_LOCKED;
      unique case (state_reg)
        fpec_pkg::FPEC_LOCKED:
          if (CMD_WDATA == `FPEC_KEY_FIRST) state_next = fpec_pkg::FPEC_KEY1;
        fpec_pkg::FPEC_KEY1:
          if (CMD_WDATA == `FPEC_KEY_SECOND) state_next = fpec_pkg::FPEC_UNLOCKED;
        fpec_pkg::FPEC_UNLOCKED: begin
          if (CMD_WDATA == `FPEC_CMD_PAGE_ERASE && !page_blocked)
            state_next = fpec_pkg::FPEC_PAGE_ARM;
          else if (mass_req && CMD_FROM_DEBUG && !mass_blocked)
            state_next = fpec_pkg::FPEC_MASS_ARM;
          else if (CMD_WDATA == `FPEC_CMD_PROGRAM)
            state_next = fpec_pkg::FPEC_PROG_ARM;
        end
        fpec_pkg::FPEC_PAGE_ARM:
          if (CMD_WDATA == `FPEC_CMD_PAGE_ERASE) state_next = fpec_pkg::FPEC_BUSY;
        fpec_pkg::FPEC_MASS_ARM:
          if (mass_req) state_next = fpec_pkg::FPEC_BUSY;
        fpec_pkg::FPEC_PROG_ARM: state_next = fpec_pkg::FPEC_LOCKED;
        fpec_pkg::FPEC_BUSY:     state_next = fpec_pkg::FPEC_BUSY;
      endcase
    end else if (prog_go) begin
      state_next = fpec_pkg::FPEC_BUSY;
    end
  end

  wire start_page = cmd_take && state_reg == fpec_pkg::FPEC_PAGE_ARM &&
                    state_next == fpec_pkg::FPEC_BUSY;
  wire start_mass = cmd_take && state_reg == fpec_pkg::FPEC_MASS_ARM &&
                    state_next == fpec_pkg::FPEC_BUSY;
  wire start_prog = !cmd_take && prog_go;
  wire [CNT_W-1:0] load_cnt = start_mass ? CNT_W'(MASS_CYC - 1) :
                              start_page ? CNT_W'(PAGE_CYC - 1) : CNT_W'(PROG_CYC - 1);
  wire start_any = start_page || start_mass || start_prog;
  wire [7:0] status_next = {is_busy, 4'h0, state_reg};
  wire info_in  = INFO_ADDR >= ADDR_BITS'(`FPEC_INFO_BASE);
  wire [ADDR_BITS-1:0] info_off = INFO_ADDR - ADDR_BITS'(`FPEC_INFO_BASE);
  wire info_ok  = info_in && info_off < ADDR_BITS'(`FPEC_INFO_WORDS);
  wire [5:0] info_idx = info_off[5:0];

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg     <= fpec_pkg::FPEC_LOCKED;
      op_reg        <= fpec_pkg::FPEC_OP_PROG;
      cnt_reg       <= '0;
      page_reg      <= '0;
      page_open_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_any) begin
        cnt_reg <= load_cnt;
        op_reg  <= start_mass ? fpec_pkg::FPEC_OP_MASS :
                   start_page ? fpec_pkg::FPEC_OP_PAGE : fpec_pkg::FPEC_OP_PROG;
      end else if (is_busy && !cnt_done) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
      if (state_reg == fpec_pkg::FPEC_KEY1 && state_next == fpec_pkg::FPEC_UNLOCKED) begin
        page_reg      <= PAGE_SEL;
        page_open_reg <= 1'b1;
      end else if (state_next == fpec_pkg::FPEC_LOCKED) begin
        page_open_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      STATUS_RDATA     <= 8'h00;
      ARRAY_PROG       <= 1'b0;
      ARRAY_PAGE_ERASE <= 1'b0;
      ARRAY_MASS_ERASE <= 1'b0;
      ARRAY_PAGE       <= '0;
      ARRAY_ADDR       <= '0;
      ARRAY_WDATA      <= 8'h00;
      OP_REFUSED       <= 1'b0;
    end else begin
      STATUS_RDATA     <= status_next;
      ARRAY_PROG       <= start_prog || (ARRAY_PROG && !(is_busy && cnt_done));
      ARRAY_PAGE_ERASE <= start_page || (ARRAY_PAGE_ERASE && !(is_busy && cnt_done));
      ARRAY_MASS_ERASE <= start_mass || (ARRAY_MASS_ERASE && !(is_busy && cnt_done));
      if (start_page) ARRAY_PAGE <= page_reg;
      if (start_prog) begin
        ARRAY_ADDR  <= PROG_ADDR;
        ARRAY_WDATA <= PROG_DATA;
      end
      OP_REFUSED <= refuse;
    end
  end

  // trim/calibration storage, loaded at factory via the load port
  always_ff @(posedge SYS_CLK) begin
    if (INFO_LOAD && info_ok) info_mem[info_idx] <= INFO_LOAD_DATA;
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      INFO_RDATA <= 8'h00;
      INFO_HIT   <= 1'b0;
    end else begin
      INFO_HIT   <= INFO_RD && info_ok;
      INFO_RDATA <= (INFO_RD && info_ok) ? info_mem[info_idx] : 8'h00;
    end
  end

  a_unlock_order: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_reg == fpec_pkg::FPEC_UNLOCKED |-> $past(state_reg) inside
      {fpec_pkg::FPEC_KEY1, fpec_pkg::FPEC_UNLOCKED})
    else $error("unlocked without both keys");
  a_bad_relock: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CMD_WR && !is_busy && state_reg == fpec_pkg::FPEC_KEY1 && CMD_WDATA != `FPEC_KEY_SECOND
      |=> state_reg == fpec_pkg::FPEC_LOCKED)
    else $error("bad key did not relock");
  a_mass_debug: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(ARRAY_MASS_ERASE) |-> $past(state_reg) == fpec_pkg::FPEC_MASS_ARM)
    else $error("mass erase without debugger arm");
  a_mass_refuse: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CMD_WR && !CMD_FROM_DEBUG && state_reg == fpec_pkg::FPEC_UNLOCKED
      |=> state_reg != fpec_pkg::FPEC_MASS_ARM)
    else $error("mass erase armed by software");
  a_busy_ignore: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy && !cnt_done |=> is_busy)
    else $error("busy ended early");
  a_busy_status: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy |=> STATUS_RDATA[`FPEC_STAT_BUSY_BIT])
    else $error("busy not in status");
  a_locked_idle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_reg == fpec_pkg::FPEC_LOCKED && !is_busy ##1 state_reg == fpec_pkg::FPEC_LOCKED
      |=> !$rose(ARRAY_PROG) && !$rose(ARRAY_PAGE_ERASE))
    else $error("operation while locked");
  a_page_only: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(ARRAY_PAGE_ERASE) |-> ARRAY_PAGE == $past(page_reg))
    else $error("erase hit wrong page");
  a_prot_mem: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    MEM_PROT && state_reg == fpec_pkg::FPEC_UNLOCKED |=> state_reg != fpec_pkg::FPEC_PAGE_ARM)
    else $error("erase armed under memory protect");
  a_one_page: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy && cnt_done |=> state_reg == fpec_pkg::FPEC_LOCKED ##0 !page_open_reg)
    else $error("page left open after operation");
  a_info_hit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    INFO_RD && INFO_ADDR < ADDR_BITS'(`FPEC_INFO_BASE) |=> !INFO_HIT)
    else $error("info hit below area");
  a_reset_lock: assert property (@(posedge SYS_CLK)
    $rose(NRST) |-> state_reg == fpec_pkg::FPEC_LOCKED && !page_open_reg)
    else $error("not locked after reset");
  a_start_seq: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(ARRAY_PROG) |-> $past(state_reg) == fpec_pkg::FPEC_PROG_ARM)
    else $error("program without arm");
  a_status_addr: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    1'b1 |=> STATUS_RDATA[2:0] == $past(state_reg))
    else $error("status does not track state");
  a_info_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !INFO_RD |=> INFO_RDATA == 8'h00)
    else $error("info data without read");
  a_op_prog: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy |-> ARRAY_PROG == (op_reg == fpec_pkg::FPEC_OP_PROG))
    else $error("program strobe does not match operation");
  a_op_page: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy |-> ARRAY_PAGE_ERASE == (op_reg == fpec_pkg::FPEC_OP_PAGE))
    else $error("page erase strobe does not match operation");
  a_op_mass: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy |-> ARRAY_MASS_ERASE == (op_reg == fpec_pkg::FPEC_OP_MASS))
    else $error("mass erase strobe does not match operation");
  a_idle_quiet: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !is_busy |-> !ARRAY_PROG && !ARRAY_PAGE_ERASE && !ARRAY_MASS_ERASE)
    else $error("array strobe while not busy");
  a_busy_end: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy && cnt_done |=> !is_busy)
    else $error("busy outlasted its count");
  a_cnt_step: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy && !cnt_done |=> cnt_reg == $past(cnt_reg) - CNT_W'(1))
    else $error("operation timer skipped");
  a_busy_cmd: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_busy && CMD_WR |=> $stable(page_reg) && state_reg inside {fpec_pkg::FPEC_BUSY, fpec_pkg::FPEC_LOCKED})
    else $error("command acted on while busy");
  a_key1_entry: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_reg == fpec_pkg::FPEC_KEY1 |-> $past(state_reg) inside {fpec_pkg::FPEC_LOCKED, fpec_pkg::FPEC_KEY1})
    else $error("first key stage entered from wrong state");
  a_page_arm_src: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_reg == fpec_pkg::FPEC_PAGE_ARM |-> $past(state_reg) inside {fpec_pkg::FPEC_UNLOCKED, fpec_pkg::FPEC_PAGE_ARM})
    else $error("page erase armed while not unlocked");
  a_mass_arm_dbg: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_reg == fpec_pkg::FPEC_MASS_ARM && $past(state_reg) == fpec_pkg::FPEC_UNLOCKED |-> $past(CMD_FROM_DEBUG))
    else $error("mass erase armed without debugger");
  a_refuse_lock: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    OP_REFUSED |-> state_reg == fpec_pkg::FPEC_LOCKED)
    else $error("refused command left controller unlocked");
  a_page_prot: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    PAGE_PROT_EN && PAGE_PROT_SEL == page_reg && state_reg == fpec_pkg::FPEC_UNLOCKED |=> state_reg != fpec_pkg::FPEC_PAGE_ARM)
    else $error("erase armed on protected page");
  a_sect_prot: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    SECTOR_PROT[tgt_sector] && state_reg == fpec_pkg::FPEC_UNLOCKED |=> state_reg != fpec_pkg::FPEC_PAGE_ARM)
    else $error("erase armed in protected sector");
  a_mass_prot: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    mass_blocked && state_reg == fpec_pkg::FPEC_UNLOCKED |=> state_reg != fpec_pkg::FPEC_MASS_ARM)
    else $error("mass erase armed under protection");
  a_prog_page: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(ARRAY_PROG) |-> ARRAY_ADDR[ADDR_BITS-1 -: PAGE_BITS] == page_reg)
    else $error("program outside open page");
  a_open_key: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(page_open_reg) |-> $past(state_reg) == fpec_pkg::FPEC_KEY1)
    else $error("page opened without unlock");
  a_info_above: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    INFO_RD && INFO_ADDR >= ADDR_BITS'(`FPEC_INFO_BASE + `FPEC_INFO_WORDS) |=> !INFO_HIT)
    else $error("info hit above implemented words");
  a_page_start: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(ARRAY_PAGE_ERASE) |-> $past(state_reg) == fpec_pkg::FPEC_PAGE_ARM)
    else $error("page erase without arm");
  a_prog_relock: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_reg == fpec_pkg::FPEC_PROG_ARM && CMD_WR |=> state_reg == fpec_pkg::FPEC_LOCKED)
    else $error("command in program arm did not relock");
  a_refuse_soft: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CMD_WR && !CMD_FROM_DEBUG && state_reg == fpec_pkg::FPEC_UNLOCKED && mass_req |=> OP_REFUSED)
    else $error("software mass erase not refused");
  a_prog_guard: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_reg == fpec_pkg::FPEC_PROG_ARM && PROG_REQ && !CMD_WR && prog_blocked |=> state_reg == fpec_pkg::FPEC_PROG_ARM)
    else $error("program started on protected target");
  a_prog_other: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_reg == fpec_pkg::FPEC_PROG_ARM && PROG_REQ && !prog_page_ok |=> !is_busy)
    else $error("program started on another page");
endmodule

/* File: sim/fpec_array_model.sv */
// flash array stand-in: measures each strobe burst and what it carried
`timescale 1ns/100ps
module fpec_array_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        prog,
  input  wire logic        page_erase,
  input  wire logic        mass_erase,
  input  wire logic [2:0]  page,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  op_len,
  output logic      [2:0]  op_kind,
  output logic      [2:0]  op_page,
  output logic      [15:0] op_addr,
  output logic      [7:0]  op_data,
  output logic      [7:0]  op_count
);
  logic [7:0] run_reg;
  wire  [2:0] kind_now = {mass_erase, page_erase, prog};
  // kinds are or-ed so overlapping strobes show up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {run_reg, op_len, op_kind, op_page, op_addr, op_data, op_count} <= '0;
    end else if (kind_now != 3'h0) begin
      run_reg <= run_reg + 8'h01;
      op_kind <= (run_reg == 8'h00) ? kind_now : (op_kind | kind_now);
      op_page <= page;
      op_addr <= addr;
      op_data <= wdata;
    end else if (run_reg != 8'h00) begin
      op_len   <= run_reg;
      run_reg  <= 8'h00;
      op_count <= op_count + 8'h01;
    end
  end
endmodule

/* File: sim/test_flash_program_erase_controller.sv */
// self-checking bench for the flash program/erase controller
`timescale 1ns/100ps
`include "fpec_consts.svh"
module test_flash_program_erase_controller;
  logic        clk = 0, nrst = 0, wr = 0, dbg = 0, mprot = 0, pp_en = 0, preq = 0, ird = 0, ild = 0;
  logic        ihit, a_pr, a_pe, a_me, refused;
  logic [7:0]  cdat = 0, sprot = 0, pdat = 0, ldat = 0, hit_data, stat_q, irdat, a_wd, o_len, o_dat, o_cnt, cnt0;
  logic [2:0]  psel = 0, pp_sel = 0, pg, a_pg, o_kind, o_pg;
  logic [15:0] paddr = 0, iaddr = 0, a_ad, o_ad;
  int          bad_count = 0, n_tests = 0, i, refused_n = 0, hit_n = 0, ref0, hit0;
  always #5 clk = ~clk;
  fpec_ctrl #(.PROG_CYC(4), .PAGE_CYC(8), .MASS_CYC(16)) dut_u (
    .SYS_CLK(clk), .NRST(nrst), .CMD_WR(wr), .CMD_WDATA(cdat), .CMD_FROM_DEBUG(dbg), .PAGE_SEL(psel),
    .SECTOR_PROT(sprot), .MEM_PROT(mprot), .PAGE_PROT_SEL(pp_sel), .PAGE_PROT_EN(pp_en), .PROG_REQ(preq),
    .PROG_ADDR(paddr), .PROG_DATA(pdat), .INFO_RD(ird), .INFO_ADDR(iaddr), .INFO_LOAD(ild),
    .INFO_LOAD_DATA(ldat), .STATUS_RDATA(stat_q), .INFO_RDATA(irdat), .INFO_HIT(ihit), .ARRAY_PROG(a_pr),
    .ARRAY_PAGE_ERASE(a_pe), .ARRAY_MASS_ERASE(a_me), .ARRAY_PAGE(a_pg), .ARRAY_ADDR(a_ad),
    .ARRAY_WDATA(a_wd), .OP_REFUSED(refused));
  fpec_array_model array_u (
    .clk(clk), .rst_n(nrst), .prog(a_pr), .page_erase(a_pe), .mass_erase(a_me), .page(a_pg), .addr(a_ad),
    .wdata(a_wd), .op_len(o_len), .op_kind(o_kind), .op_page(o_pg), .op_addr(o_ad), .op_data(o_dat),
    .op_count(o_cnt));
  // one-cycle pulses are caught here
  always @(posedge clk) begin
    if (refused === 1'b1) refused_n <= refused_n + 1;
    if (ihit === 1'b1) begin
      hit_n    <= hit_n + 1;
      hit_data <= irdat;
    end
  end
  function automatic logic [7:0] st_byte(input logic [2:0] st);
    return {st == 3'h7, 4'h0, st};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] v);
    @(posedge clk);
    wr   <= 1'b1;
    cdat <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic stat(input logic [2:0] st);
    #1 check(stat_q, st_byte(st));
  endtask
  task automatic unlock(input logic [2:0] p);
    cmd(8'h00);
    psel <= p;
    cmd(`FPEC_KEY_FIRST);
    cmd(`FPEC_KEY_SECOND);
  endtask
  task automatic wait_op(input logic [2:0] kind, input logic [7:0] len);
    for (i = 0; i < 200 && o_cnt == cnt0; i++) @(posedge clk);
    if (o_cnt == cnt0) bad_count++;
    #1 check(o_kind, kind);
    check(o_len, len);
  endtask
  task automatic refusal(input logic [7:0] c);
    ref0 = refused_n;
    cnt0 = o_cnt;
    cmd(c);
    cmd(c);
    repeat (2) @(posedge clk);
    check(refused_n - ref0, 1);
    check(o_cnt, cnt0);
  endtask
  initial begin
    void'($urandom(32'h7135));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    stat(`FPEC_STAT_LOCKED);
    cmd(`FPEC_CMD_PAGE_ERASE);
    stat(`FPEC_STAT_LOCKED);
    for (int k = 0; k < 3; k++) begin
      pg = 3'($urandom_range(7, 0));
      unlock(pg);
      stat(`FPEC_STAT_UNLOCKED);
      cmd(`FPEC_CMD_PAGE_ERASE);
      stat(`FPEC_STAT_PAGE_ARM);
      cnt0 = o_cnt;
      cmd(`FPEC_CMD_PAGE_ERASE);
      stat(3'h7);
      cmd(`FPEC_KEY_FIRST);
      wait_op(3'b010, 8'h08);
      check(o_pg, pg);
      stat(`FPEC_STAT_LOCKED);
    end
    cmd(`FPEC_KEY_SECOND);
    stat(`FPEC_STAT_LOCKED);
    cmd(`FPEC_KEY_FIRST);
    stat(`FPEC_STAT_KEY1);
    cmd(8'($urandom_range(8'h8B, 8'h74)));
    stat(`FPEC_STAT_LOCKED);
    unlock(3'h2);
    cmd(8'($urandom_range(8'h62, 8'h00)));
    stat(`FPEC_STAT_LOCKED);
    unlock(3'h0);
    refusal(`FPEC_CMD_MASS_ERASE);
    dbg <= 1'b1;
    unlock(3'h0);
    cmd(`FPEC_CMD_MASS_ERASE);
    stat(`FPEC_STAT_MASS_ARM);
    cnt0 = o_cnt;
    cmd(`FPEC_CMD_MASS_ERASE);
    wait_op(3'b100, 8'h10);
    for (int k = 0; k < 3; k++) begin
      pg = 3'($urandom_range(7, 0));
      @(posedge clk);
      dbg    <= 1'b0;
      mprot  <= (k == 0);
      pp_en  <= (k == 1);
      pp_sel <= pg;
      sprot  <= (k == 2) ? (8'h01 << pg) : 8'h00;
      unlock(pg);
      refusal(`FPEC_CMD_PAGE_ERASE);
    end
    @(posedge clk);
    {mprot, pp_en, sprot} <= '0;
    pg = 3'($urandom_range(7, 0));
    unlock(pg);
    cmd(`FPEC_CMD_PROGRAM);
    stat(`FPEC_STAT_PROG_ARM);
    cnt0 = o_cnt;
    for (int j = 0; j < 3; j++) begin
      @(posedge clk);
      paddr  <= {pg + 3'(j == 0), 13'($urandom)};
      pdat   <= 8'($urandom);
      pp_sel <= pg;
      pp_en  <= (j == 1);
      preq   <= 1'b1;
      @(posedge clk);
      preq <= 1'b0;
      if (j < 2) begin
        repeat (6) @(posedge clk);
        check(o_cnt, cnt0);
        stat(`FPEC_STAT_PROG_ARM);
      end
    end
    wait_op(3'b001, 8'h04);
    check(o_ad, paddr);
    check(o_dat, pdat);
    hit0 = hit_n;
    @(posedge clk);
    iaddr <= `FPEC_INFO_BASE + 16'($urandom_range(63, 0));
    ldat  <= 8'($urandom);
    ild   <= 1'b1;
    @(posedge clk);
    ild <= 1'b0;
    ird <= 1'b1;
    @(posedge clk);
    ird <= 1'b0;
    @(posedge clk);
    #1 check(hit_n - hit0, 1);
    check(hit_data, ldat);
    hit0 = hit_n;
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      iaddr <= j ? `FPEC_INFO_BASE + 16'h0040 + 16'($urandom_range(447, 0)) : 16'($urandom_range(16'hFDFF, 0));
      ird   <= 1'b1;
      @(posedge clk);
      ird <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check(hit_n - hit0, 0);
      check(irdat, 0);
    end
    unlock(3'h5);
    cmd(`FPEC_CMD_PAGE_ERASE);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    stat(`FPEC_STAT_LOCKED);
    check(a_pe, 0);
    unlock(3'h1);
    stat(`FPEC_STAT_UNLOCKED);
    tally_and_finish();
  end
endmodule
